/* File: drm_fault_enc.sv */
// fault reason encoder top: registers the reason of each walk, keeps config and status registers
// assumes the walker and the register master share core_clk_i
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps

module drm_fault_enc #(
  parameter logic [6:0] MAX_GUEST_ADDR_WIDTH = 7'd48,
  parameter logic [drm_pkg::AW_CODES-1:0] AW_SUP = 5'h04,
  parameter logic [drm_pkg::TT_CODES-1:0] TT_SUP = 4'h5
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // walk results
  input wire drm_pkg::drm_walk_t walk_i,
  // register port
  input wire drm_pkg::drm_bus_req_t bus_i,
  output logic [31:0] rd_data_o,
  // fault report and interrupt
  output drm_pkg::drm_fault_t fault_o,
  output logic irq_o
);
  import drm_pkg::*;

  // ******************************************************
  // state
  // ******************************************************
  typedef struct packed {
    drm_cfg_t cfg;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [7:0] last_code;
    logic [15:0] count;
    drm_fault_t fault;
    logic irq;
    logic [31:0] rd_data;
  } drm_state_t;

  drm_state_t st;
  drm_state_t next_st;
  logic [7:0] sel_code;
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] clr;
  logic [ST_W-1:0] next_status;

  drm_reason_sel u_sel (
    .walk_i(walk_i),
    .cfg_i(st.cfg),
    .code_o(sel_code)
  );

  // ******************************************************
  // next state
  // ******************************************************
  always_comb begin
    next_st = st;
    ev = '0;
    clr = '0;
    // report on the cycle after the walk, one code per request
    next_st.fault.valid = walk_i.valid && (sel_code != RSN_NONE);
    next_st.fault.code = walk_i.valid ? sel_code : RSN_NONE;
    if (next_st.fault.valid) begin
      next_st.last_code = sel_code;
      next_st.count = st.count + 16'h0001;
      ev[ST_FAULT] = 1'b1;
      ev[ST_FETCH] = (sel_code == RSN_ROOT_FETCH) || (sel_code == RSN_CTX_FETCH)
                     || (sel_code == RSN_PT_FETCH) || ((sel_code == RSN_CTX_BAD) && walk_i.asr_fetch_err);
      ev[ST_PERM] = (sel_code == RSN_NO_WRITE) || (sel_code == RSN_NO_READ);
    end
    if (bus_i.wr) begin
      case (bus_i.addr)
        OFS_CFG: begin
          next_st.cfg.max_guest_addr_width = bus_i.wdata[6:0];
          next_st.cfg.zero_len_read_cap = bus_i.wdata[CFG_ZLR_BIT];
        end
        OFS_SUPPORT: begin
          next_st.cfg.aw_sup = bus_i.wdata[AW_CODES-1:0];
          next_st.cfg.tt_sup = bus_i.wdata[SUP_TT_LSB +: TT_CODES];
        end
        OFS_STATUS: clr = bus_i.wdata[ST_W-1:0];
        OFS_MASK: next_st.mask = bus_i.wdata[ST_W-1:0];
        default: ;
      endcase
    end
    // a new event outlives a clear in the same cycle
    next_status = (st.status & ~clr) | ev;
    next_st.status = next_status;
    next_st.irq = |(next_status & st.mask);
    next_st.rd_data = 32'h0;
    if (bus_i.rd) begin
      case (bus_i.addr)
        OFS_CFG: begin
          next_st.rd_data[6:0] = st.cfg.max_guest_addr_width;
          next_st.rd_data[CFG_ZLR_BIT] = st.cfg.zero_len_read_cap;
        end
        OFS_SUPPORT: begin
          next_st.rd_data[AW_CODES-1:0] = st.cfg.aw_sup;
          next_st.rd_data[SUP_TT_LSB +: TT_CODES] = st.cfg.tt_sup;
        end
        OFS_STATUS: next_st.rd_data[ST_W-1:0] = st.status;
        OFS_MASK: next_st.rd_data[ST_W-1:0] = st.mask;
        OFS_LAST: begin
          next_st.rd_data[7:0] = st.last_code;
          next_st.rd_data[LAST_CNT_LSB +: 16] = st.count;
        end
        default: next_st.rd_data = 32'h0;
      endcase
    end
  end

  // ******************************************************
  // registers
  // ******************************************************
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st <= '0;
      st.cfg.max_guest_addr_width <= MAX_GUEST_ADDR_WIDTH;
      st.cfg.aw_sup <= AW_SUP;
      st.cfg.tt_sup <= TT_SUP;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data_o = st.rd_data;
  assign fault_o = st.fault;
  assign irq_o = st.irq;

  // ******************************************************
  // checks
  // ******************************************************
  logic root_ok;
  logic ctx_ok;
  logic cfg_ok;
  logic range_ok;
  logic pt_ok;
  logic [6:0] chk_aw;
  logic [6:0] chk_x;

  always_comb begin
    chk_aw = 7'(AW_BASE + AW_STEP * int'(walk_i.address_width_field));
    chk_x = (chk_aw < st.cfg.max_guest_addr_width) ? chk_aw : st.cfg.max_guest_addr_width;
    root_ok = walk_i.valid && !walk_i.root_fetch_err && walk_i.root_present && !walk_i.root_rsvd_nz;
    ctx_ok = root_ok && !walk_i.ctx_fetch_err && walk_i.ctx_present && !walk_i.ctx_rsvd_nz;
    cfg_ok = ctx_ok && (int'(walk_i.address_width_field) < AW_CODES)
             && st.cfg.aw_sup[walk_i.address_width_field]
             && st.cfg.tt_sup[walk_i.translation_type_field] && !walk_i.asr_fetch_err;
    // a limit of 64 bits or more can never be overrun
    range_ok = cfg_ok && ((chk_x >= 7'h40) || ((walk_i.addr >> chk_x) == 64'h0));
    pt_ok = range_ok && !walk_i.pt_fetch_err;
  end

  sequence s_code(logic [7:0] c);
    ##1 (fault_o.valid && fault_o.code == c);
  endsequence

  sequence s_no_code(logic [7:0] c);
    ##1 !(fault_o.valid && fault_o.code == c);
  endsequence

  property p_never_zero;
    @(posedge core_clk_i) disable iff (reset_i)
      fault_o.valid |-> fault_o.code != RSN_NONE;
  endproperty
  a_never_zero: assert property (p_never_zero) else $error("fault shown with code zero");

  property p_root_np;
    @(posedge core_clk_i) disable iff (reset_i)
      walk_i.valid && !walk_i.root_fetch_err && !walk_i.root_present |-> s_code(RSN_ROOT_NP);
  endproperty
  a_root_np: assert property (p_root_np) else $error("root not present not coded 1h");

  property p_ctx_np;
    @(posedge core_clk_i) disable iff (reset_i)
      root_ok && !walk_i.ctx_fetch_err && !walk_i.ctx_present |-> s_code(RSN_CTX_NP);
  endproperty
  a_ctx_np: assert property (p_ctx_np) else $error("context not present not coded 2h");

  property p_ctx_prog;
    @(posedge core_clk_i) disable iff (reset_i)
      ctx_ok && !st.cfg.tt_sup[walk_i.translation_type_field] |-> s_code(RSN_CTX_BAD);
  endproperty
  a_ctx_prog: assert property (p_ctx_prog) else $error("bad translation type not coded 3h");

  property p_asr_err;
    @(posedge core_clk_i) disable iff (reset_i)
      ctx_ok && walk_i.asr_fetch_err |-> s_code(RSN_CTX_BAD);
  endproperty
  a_asr_err: assert property (p_asr_err) else $error("root pointer fetch error not coded 3h");

  property p_range;
    @(posedge core_clk_i) disable iff (reset_i)
      cfg_ok && !range_ok |-> s_code(RSN_ADDR_RANGE);
  endproperty
  a_range: assert property (p_range) else $error("address overrun not coded 4h");

  property p_no_write;
    @(posedge core_clk_i) disable iff (reset_i)
      pt_ok && walk_i.is_write && !walk_i.pte_write |-> s_code(RSN_NO_WRITE);
  endproperty
  a_no_write: assert property (p_no_write) else $error("write without permission not coded 5h");

  property p_no_read;
    @(posedge core_clk_i) disable iff (reset_i)
      pt_ok && walk_i.is_read && !walk_i.is_write && !walk_i.pte_read && !walk_i.zero_len
      && (walk_i.pte_write || !walk_i.is_atomic) |-> s_code(RSN_NO_READ);
  endproperty
  a_no_read: assert property (p_no_read) else $error("read without permission not coded 6h");

  property p_zlr;
    @(posedge core_clk_i) disable iff (reset_i)
      pt_ok && st.cfg.zero_len_read_cap && walk_i.zero_len && walk_i.is_read && walk_i.pte_write
      && !walk_i.is_atomic |-> s_no_code(RSN_NO_READ);
  endproperty
  a_zlr: assert property (p_zlr) else $error("zero-length read faulted on write-only page");

  property p_pt_fetch;
    @(posedge core_clk_i) disable iff (reset_i)
      range_ok && walk_i.pt_fetch_err |-> s_code(RSN_PT_FETCH);
  endproperty
  a_pt_fetch: assert property (p_pt_fetch) else $error("page table fetch error not coded 7h");

  property p_root_fetch;
    @(posedge core_clk_i) disable iff (reset_i)
      walk_i.valid && walk_i.root_fetch_err |-> s_code(RSN_ROOT_FETCH);
  endproperty
  a_root_fetch: assert property (p_root_fetch) else $error("root fetch error not coded 8h");

  property p_ctx_fetch;
    @(posedge core_clk_i) disable iff (reset_i)
      root_ok && walk_i.ctx_fetch_err |-> s_code(RSN_CTX_FETCH);
  endproperty
  a_ctx_fetch: assert property (p_ctx_fetch) else $error("context fetch error not coded 9h");

  property p_root_rsvd;
    @(posedge core_clk_i) disable iff (reset_i)
      walk_i.valid && !walk_i.root_fetch_err && walk_i.root_present && walk_i.root_rsvd_nz
      |-> s_code(RSN_ROOT_RSVD);
  endproperty
  a_root_rsvd: assert property (p_root_rsvd) else $error("root reserved bits not coded Ah");

  property p_ctx_rsvd;
    @(posedge core_clk_i) disable iff (reset_i)
      root_ok && !walk_i.ctx_fetch_err && walk_i.ctx_present && walk_i.ctx_rsvd_nz
      |-> s_code(RSN_CTX_RSVD);
  endproperty
  a_ctx_rsvd: assert property (p_ctx_rsvd) else $error("context reserved bits not coded Bh");

  property p_one_per_req;
    @(posedge core_clk_i) disable iff (reset_i)
      !walk_i.valid |=> !fault_o.valid;
  endproperty
  a_one_per_req: assert property (p_one_per_req) else $error("fault shown without a request");

  property p_clean_pass;
    @(posedge core_clk_i) disable iff (reset_i)
      pt_ok && !walk_i.is_write && !walk_i.is_read && !walk_i.is_atomic |=> !fault_o.valid;
  endproperty
  a_clean_pass: assert property (p_clean_pass) else $error("passing request faulted");

  property p_irq;
    @(posedge core_clk_i) disable iff (reset_i)
      fault_o.valid && $past(st.mask[ST_FAULT]) |-> irq_o && st.status[ST_FAULT];
  endproperty
  a_irq: assert property (p_irq) else $error("masked-in fault did not raise interrupt");

endmodule : drm_fault_enc

/* File: drm_pkg.sv */
// fault reason codes, register map and carrier types for the dma remap fault encoder
// assumes a single core clock domain shared with the table walker
package drm_pkg;

  // ******************************************************
  // fault reason encodings
  // ******************************************************
  localparam logic [7:0] RSN_NONE = 8'h00;
  localparam logic [7:0] RSN_ROOT_NP = 8'h01;
  localparam logic [7:0] RSN_CTX_NP = 8'h02;
  localparam logic [7:0] RSN_CTX_BAD = 8'h03;
  localparam logic [7:0] RSN_ADDR_RANGE = 8'h04;
  localparam logic [7:0] RSN_NO_WRITE = 8'h05;
  localparam logic [7:0] RSN_NO_READ = 8'h06;
  localparam logic [7:0] RSN_PT_FETCH = 8'h07;
  localparam logic [7:0] RSN_ROOT_FETCH = 8'h08;
  localparam logic [7:0] RSN_CTX_FETCH = 8'h09;
  localparam logic [7:0] RSN_ROOT_RSVD = 8'h0a;
  localparam logic [7:0] RSN_CTX_RSVD = 8'h0b;

  // ******************************************************
  // register map (byte offsets) and fields
  // ******************************************************
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_SUPPORT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  localparam logic [7:0] OFS_LAST = 8'h10;
  localparam int CFG_ZLR_BIT = 8;
  localparam int SUP_TT_LSB = 8;
  localparam int LAST_CNT_LSB = 16;
  localparam int ST_FAULT = 0;
  localparam int ST_FETCH = 1;
  localparam int ST_PERM = 2;
  localparam int ST_W = 3;

  // address width field: width = base + step * value
  localparam int AW_BASE = 30;
  localparam int AW_STEP = 9;
  localparam int AW_CODES = 5;
  localparam int TT_CODES = 4;

  // ******************************************************
  // carriers
  // ******************************************************
  typedef struct packed {
    logic valid;
    logic is_read;
    logic is_write;
    logic is_atomic;
    logic zero_len;
    logic [63:0] addr;
    logic root_fetch_err;
    logic root_present;
    logic root_rsvd_nz;
    logic ctx_fetch_err;
    logic ctx_present;
    logic ctx_rsvd_nz;
    logic [2:0] address_width_field;
    logic [1:0] translation_type_field;
    logic asr_fetch_err;
    logic pt_fetch_err;
    logic pte_read;
    logic pte_write;
  } drm_walk_t;

  typedef struct packed {
    logic [6:0] max_guest_addr_width;
    logic zero_len_read_cap;
    logic [AW_CODES-1:0] aw_sup;
    logic [TT_CODES-1:0] tt_sup;
  } drm_cfg_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } drm_fault_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } drm_bus_req_t;

endpackage : drm_pkg

/* File: drm_reason_sel.sv */
// combinational choice of one fault reason for a finished table walk
// assumes the walk record is stable while valid is high
`timescale 1ns/1ps

module drm_reason_sel (
  // walk record and configuration
  input wire drm_pkg::drm_walk_t walk_i,
  input wire drm_pkg::drm_cfg_t cfg_i,
  // chosen reason, zero when the request passes
  output logic [7:0] code_o
);
  import drm_pkg::*;

  logic [6:0] aw_bits;
  logic [6:0] lim_bits;
  logic aw_ok;
  logic tt_ok;
  logic over;
  logic zlr_skip;

  always_comb begin
    aw_ok = (int'(walk_i.address_width_field) < AW_CODES) && cfg_i.aw_sup[walk_i.address_width_field];
    tt_ok = cfg_i.tt_sup[walk_i.translation_type_field];
    aw_bits = 7'(AW_BASE + AW_STEP * int'(walk_i.address_width_field));
    lim_bits = (aw_bits < cfg_i.max_guest_addr_width) ? aw_bits : cfg_i.max_guest_addr_width;
    over = (lim_bits < 7'h40) && ((walk_i.addr >> lim_bits) != 64'h0);
    zlr_skip = cfg_i.zero_len_read_cap && walk_i.zero_len && walk_i.is_read && !walk_i.is_atomic
               && walk_i.pte_write;
    // walk order sets priority, so only the first failing check is reported
    code_o = RSN_NONE;
    if (walk_i.root_fetch_err) code_o = RSN_ROOT_FETCH;
    else if (!walk_i.root_present) code_o = RSN_ROOT_NP;
    else if (walk_i.root_rsvd_nz) code_o = RSN_ROOT_RSVD;
    else if (walk_i.ctx_fetch_err) code_o = RSN_CTX_FETCH;
    else if (!walk_i.ctx_present) code_o = RSN_CTX_NP;
    else if (walk_i.ctx_rsvd_nz) code_o = RSN_CTX_RSVD;
    else if (!aw_ok || !tt_ok) code_o = RSN_CTX_BAD;
    else if (walk_i.asr_fetch_err) code_o = RSN_CTX_BAD;
    else if (over) code_o = RSN_ADDR_RANGE;
    else if (walk_i.pt_fetch_err) code_o = RSN_PT_FETCH;
    else if ((walk_i.is_write || walk_i.is_atomic) && !walk_i.pte_write) code_o = RSN_NO_WRITE;
    else if ((walk_i.is_read || walk_i.is_atomic) && !walk_i.pte_read && !zlr_skip) begin
      code_o = RSN_NO_READ;
    end
  end

endmodule : drm_reason_sel

/* File: drm_walk_src.sv */
// far-side model: issues one finished walk record per request into the fault encoder
// assumes the bench hands it a record and a one-cycle go strobe on core_clk_i
`timescale 1ns/1ps

module drm_walk_src (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // bench command
  input wire drm_pkg::drm_walk_t rec_i,
  input wire logic go_i,
  // walk record towards the encoder
  output drm_pkg::drm_walk_t walk_o
);
  import drm_pkg::*;

  // ******************************************************
  // record driver
  // ******************************************************
  // between requests every field but valid toggles every cycle so a stale value can never pass for a sampled one
  drm_walk_t nxt;

  always_comb begin
    nxt = go_i ? rec_i : ~walk_o;
    nxt.valid = go_i;
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      walk_o <= '0;
    end else begin
      walk_o <= nxt;
    end
  end
endmodule : drm_walk_src

/* File: testbench.sv */
// self-checking bench for the dma remap fault reason encoder
// assumes drm_pkg, drm_fault_enc and the walk source model are compiled before it
`timescale 1ns/1ps

module testbench;
  import drm_pkg::*;

  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  drm_bus_req_t bus = '0;
  drm_walk_t rec = '0;
  logic go = 1'b0;
  drm_walk_t walk;
  logic [31:0] rd_data;
  drm_fault_t fault;
  logic irq;
  int miscompares = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [15:0] nf = 16'h0;
  logic [7:0] last = 8'h00;

  always #2.5 core_clk_i = ~core_clk_i;

  drm_walk_src u_drm_walk_src (.core_clk_i(core_clk_i), .reset_i(reset_i), .rec_i(rec), .go_i(go), .walk_o(walk));
  drm_fault_enc u_drm_fault_enc (.core_clk_i(core_clk_i), .reset_i(reset_i), .walk_i(walk), .bus_i(bus),
    .rd_data_o(rd_data), .fault_o(fault), .irq_o(irq));

  // ******************************************************
  // shared tasks
  // ******************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_i);
    bus <= '0;
  endtask : bus_wr

  // read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge core_clk_i);
    bus <= '0;
    #1;
    check($sformatf("rd_data at %h", a), rd_data, exp);
  endtask : bus_rd

  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask : tick

  function automatic drm_walk_t base();
    drm_walk_t r;
    r = '0;
    r.is_read = 1'b1;
    r.root_present = 1'b1;
    r.ctx_present = 1'b1;
    r.address_width_field = 3'd2;
    r.pte_read = 1'b1;
    r.pte_write = 1'b1;
    r.addr = 64'h1000;
    return r;
  endfunction : base

  // one request; the answer must come exactly one edge after the record is taken, then drop
  task automatic send(input drm_walk_t r, input logic [7:0] exp);
    @(posedge core_clk_i);
    rec <= r;
    go <= 1'b1;
    @(posedge core_clk_i);
    go <= 1'b0;
    tick();
    check("fault valid", fault.valid, exp != 8'h00);
    if (exp != 8'h00) begin
      check("fault code", fault.code, exp);
      nf++;
      last = exp;
    end
    tick();
    check("fault pulse end", fault.valid, 1'b0);
  endtask : send

  // ******************************************************
  // scenarios
  // ******************************************************
  task automatic t_reset_regs();
    bus_rd(OFS_CFG, 32'h30);
    bus_rd(OFS_SUPPORT, 32'h504);
    bus_rd(OFS_STATUS, 32'h0);
    bus_rd(OFS_MASK, 32'h0);
    bus_rd(OFS_LAST, 32'h0);
    check("irq idle", irq, 1'b0);
  endtask : t_reset_regs

  // each condition, alone or paired with a lower-priority one to exercise the priority order
  task automatic t_codes();
    drm_walk_t r;
    logic [7:0] e;
    for (int i = 0; i < 20; i++) begin
      r = base();
      case (i)
        0: begin r.root_fetch_err = 1'b1; r.root_present = 1'b0; e = 8'h08; end
        1: begin r.root_present = 1'b0; r.ctx_fetch_err = 1'b1; e = 8'h01; end
        2: begin r.root_rsvd_nz = 1'b1; r.ctx_present = 1'b0; e = 8'h0a; end
        3: begin r.ctx_fetch_err = 1'b1; e = 8'h09; end
        4: begin r.ctx_present = 1'b0; r.ctx_rsvd_nz = 1'b1; e = 8'h02; end
        5: begin r.ctx_rsvd_nz = 1'b1; r.asr_fetch_err = 1'b1; e = 8'h0b; end
        6: begin r.address_width_field = 3'd1; e = 8'h03; end
        7: begin r.address_width_field = 3'd5; e = 8'h03; end
        8: begin r.translation_type_field = 2'd1; e = 8'h03; end
        9: begin r.asr_fetch_err = 1'b1; r.addr = 64'h1 << 48; e = 8'h03; end
        10: begin r.addr = 64'h1 << 48; r.pt_fetch_err = 1'b1; e = 8'h04; end
        11: begin r.addr = (64'h1 << 48) - 64'h1; e = 8'h00; end
        12: begin r.pt_fetch_err = 1'b1; r.pte_read = 1'b0; e = 8'h07; end
        13: begin r.is_read = 1'b0; r.is_write = 1'b1; r.pte_write = 1'b0; e = 8'h05; end
        14: begin r.is_atomic = 1'b1; r.pte_write = 1'b0; r.pte_read = 1'b0; e = 8'h05; end
        15: begin r.pte_read = 1'b0; e = 8'h06; end
        16: begin r.is_read = 1'b0; r.is_atomic = 1'b1; r.pte_read = 1'b0; e = 8'h06; end
        17: begin r.is_read = 1'b0; r.is_write = 1'b1; r.pte_read = 1'b0; e = 8'h00; end
        18: begin r.is_read = 1'b0; r.pte_read = 1'b0; r.pte_write = 1'b0; e = 8'h00; end
        default: begin r.translation_type_field = 2'd2; e = 8'h00; end
      endcase
      send(r, e);
    end
  endtask : t_codes

  // a narrower guest width must win over the context width
  task automatic t_addr_limit();
    drm_walk_t r;
    bus_wr(OFS_CFG, 32'h28);
    r = base();
    r.addr = 64'h1 << 40;
    send(r, 8'h04);
    r.addr = (64'h1 << 40) - 64'h1;
    send(r, 8'h00);
    bus_wr(OFS_CFG, 32'h30);
  endtask : t_addr_limit

  task automatic t_zero_len();
    drm_walk_t r;
    r = base();
    r.pte_read = 1'b0;
    r.zero_len = 1'b1;
    send(r, 8'h06);
    bus_wr(OFS_CFG, 32'h130);
    bus_rd(OFS_CFG, 32'h130);
    send(r, 8'h00);
    r.zero_len = 1'b0;
    send(r, 8'h06);
    r.zero_len = 1'b1;
    r.is_atomic = 1'b1;
    send(r, 8'h06);
    bus_wr(OFS_CFG, 32'h30);
  endtask : t_zero_len

  task automatic t_back_to_back();
    drm_walk_t a;
    drm_walk_t b;
    a = base();
    a.root_present = 1'b0;
    b = base();
    b.ctx_present = 1'b0;
    @(posedge core_clk_i);
    rec <= a;
    go <= 1'b1;
    @(posedge core_clk_i);
    rec <= b;
    @(posedge core_clk_i);
    go <= 1'b0;
    #1;
    check("first code", {fault.valid, fault.code}, {1'b1, 8'h01});
    tick();
    check("second code", {fault.valid, fault.code}, {1'b1, 8'h02});
    tick();
    check("pair end", fault.valid, 1'b0);
    nf += 16'h2;
    last = 8'h02;
  endtask : t_back_to_back

  task automatic t_irq();
    drm_walk_t r;
    bus_wr(OFS_STATUS, 32'h7);
    bus_wr(OFS_MASK, 32'h1);
    bus_rd(OFS_STATUS, 32'h0);
    r = base();
    r.root_fetch_err = 1'b1;
    send(r, 8'h08);
    check("irq any", irq, 1'b1);
    bus_rd(OFS_STATUS, 32'h3);
    bus_wr(OFS_MASK, 32'h4);
    tick();
    check("irq masked", irq, 1'b0);
    r = base();
    r.pte_read = 1'b0;
    send(r, 8'h06);
    check("irq perm", irq, 1'b1);
    bus_rd(OFS_STATUS, 32'h7);
    bus_rd(OFS_LAST, {nf, 8'h00, last});
    bus_wr(OFS_STATUS, 32'h7);
    tick();
    check("irq cleared", irq, 1'b0);
    bus_rd(OFS_STATUS, 32'h0);
    bus_wr(8'h20, 32'hffffffff);
    bus_rd(8'h20, 32'h0);
    bus_rd(OFS_MASK, 32'h4);
  endtask : t_irq

  // ******************************************************
  // main sequence and hang guard
  // ******************************************************
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    repeat (5) @(posedge core_clk_i);
    reset_i <= 1'b0;
    t_reset_regs();
    t_codes();
    t_addr_limit();
    t_zero_len();
    t_back_to_back();
    t_irq();
    final_report();
  end
endmodule : testbench
